// File: hdl/eea_line_sync.sv
`timescale 1ns/1ps
module eea_line_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Pins
  input wire logic sclPin,
  input wire logic sdaPin,
  input wire logic wpPin,
  input wire logic [2:0] csPin,
  // Synchronised levels and events
  output logic sclLvl,
  output logic sdaLvl,
  output logic wpLvl,
  output logic [2:0] csLvl,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);

  // ==========================================================================
  // Two-stage synchronisers, then one delay stage for edge detection
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic sclDly_q;
  logic sdaDly_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 6'h3f;
      sync_q <= 6'h3f;
      sclDly_q <= 1'b1;
      sdaDly_q <= 1'b1;
    end
    else if (clkEn)
    begin
      meta_q <= {csPin, wpPin, sdaPin, sclPin};
      sync_q <= meta_q;
      sclDly_q <= sync_q[0];
      sdaDly_q <= sync_q[1];
    end
  end

  assign sclLvl = sync_q[0];
  assign sdaLvl = sync_q[1];
  assign wpLvl = sync_q[2];
  assign csLvl = sync_q[5:3];
  assign sclRise = sync_q[0] & ~sclDly_q;
  assign sclFall = ~sync_q[0] & sclDly_q;
  // Data moving while the clock stays high marks Start or Stop.
  assign startSeen = sync_q[0] & sclDly_q & sdaDly_q & ~sync_q[1];
  assign stopSeen = sync_q[0] & sclDly_q & ~sdaDly_q & sync_q[1];

endmodule

// File: hdl/eea_map.svh
`ifndef EEA_MAP_SVH
`define EEA_MAP_SVH

// ==========================================================================
// Array and page geometry
`define EEA_ADDR_W 15
`define EEA_HI_W 7
`define EEA_PAGE_W 6
`define EEA_BASE_W 9
`define EEA_BYTES 32768
`define EEA_PAGE_BYTES 64

// ==========================================================================
// Control byte fields
`define EEA_CTRL_TYPE_HI 7
`define EEA_CTRL_TYPE_LO 4
`define EEA_CTRL_CS_HI 3
`define EEA_CTRL_CS_LO 1
`define EEA_CTRL_RW 0

// ==========================================================================
// Byte positions within a command
`define EEA_IDX_CTRL 2'h0
`define EEA_IDX_ADDR_HI 2'h1
`define EEA_IDX_ADDR_LO 2'h2
`define EEA_IDX_DATA 2'h3

// ==========================================================================
// Timing: self-timed write cycle length in ref_clk cycles, at least 64
`define EEA_WRITE_CYCLES 16'h0fa0

`endif

// File: hdl/eea_pkg.sv
package eea_pkg;

  // ==========================================================================
  // Serial protocol states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_RECV   = 6'b000010,
    ST_ACK    = 6'b000100,
    ST_SEND   = 6'b001000,
    ST_MACK   = 6'b010000,
    ST_IGNORE = 6'b100000
  } eea_state_t;

  typedef logic [14:0] eea_addr_t;

endpackage

// File: hdl/eea_serial_eeprom.sv
`timescale 1ns/1ps
`include "eea_map.svh"
// What this block does
// - Byte write: control, two address, data
// - Stop starts write cycle; no acks meanwhile
// - Protected write acked, discarded, instantly ready
// - After byte write, pointer is address plus one within its page
// - Page write buffers up to 64 bytes
// - Data bytes increment only six low bits
// - Page overrun wraps within the same page
// - Protect pin covers array, sampled at Stop
// - Busy withholds control ack; ack once done
// - Current read returns last address plus one
// - Read control acked, eight bits shifted out
// - Address bytes load pointer before restart
// - After random read, pointer is next location
// - Master ack requests next sequential byte
// - Pointer wraps from 7FFF to 0000
// - Ack control only on type and select match
// - Only fifteen address bits are used
// - Master no-ack releases data line high
module eea_serial_eeprom #(
  // Device type code; this value is arbitrary.
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter logic [15:0] WRITE_CYCLES = `EEA_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Two-wire bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Straps
  input wire logic writeProtect,
  input wire logic chipSelectBit0,
  input wire logic chipSelectBit1,
  input wire logic chipSelectBit2,
  // Status
  output logic writeBusy
);

  // ==========================================================================
  // Pin synchronisation
  logic sclLvl, sdaLvl, wpLvl;
  logic [2:0] csLvl;
  logic sclRise, sclFall, startSeen, stopSeen;

  eea_line_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .wpPin(writeProtect),
    .csPin({chipSelectBit2, chipSelectBit1, chipSelectBit0}),
    .sclLvl(sclLvl),
    .sdaLvl(sdaLvl),
    .wpLvl(wpLvl),
    .csLvl(csLvl),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // ==========================================================================
  // Storage and state
  logic [7:0] mem [0:`EEA_BYTES-1];
  logic [7:0] pageBuf [0:`EEA_PAGE_BYTES-1];
  eea_pkg::eea_state_t state_q, state_d;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteIdx_q;
  logic full_q, isRead_q, mackOk_q, gotData_q, busy_q, sdaOe_q, sdaOut_q;
  logic [`EEA_HI_W-1:0] hi_q;
  eea_pkg::eea_addr_t ptr_q, ptr_d;
  logic [`EEA_PAGE_BYTES-1:0] valid_q;
  logic [15:0] timer_q;
  logic [`EEA_BASE_W-1:0] base_q;

  function automatic eea_pkg::eea_addr_t incAddr(input eea_pkg::eea_addr_t a, input logic pageOnly);
    eea_pkg::eea_addr_t full;
    full = a + 15'h0001;
    incAddr = pageOnly ? {a[14:6], full[5:0]} : full;
  endfunction

  // ==========================================================================
  // Decoding of bus events
  wire byteDone = (state_q == eea_pkg::ST_RECV) & full_q & sclFall;
  wire ctrlMatch = (shift_q[`EEA_CTRL_TYPE_HI:`EEA_CTRL_TYPE_LO] == DEV_TYPE) &
                   (shift_q[`EEA_CTRL_CS_HI:`EEA_CTRL_CS_LO] == csLvl);
  wire idxCtrl = (byteIdx_q == `EEA_IDX_CTRL);
  wire ctrlAck = idxCtrl & ctrlMatch & ~busy_q;
  wire byteAck = idxCtrl ? ctrlAck : 1'b1;
  wire hiLoad = byteDone & (byteIdx_q == `EEA_IDX_ADDR_HI);
  wire addrLoad = byteDone & (byteIdx_q == `EEA_IDX_ADDR_LO);
  wire dataStore = byteDone & (byteIdx_q == `EEA_IDX_DATA);
  wire ackEnd = (state_q == eea_pkg::ST_ACK) & sclFall;
  wire readFirst = ackEnd & isRead_q;
  wire readNext = (state_q == eea_pkg::ST_MACK) & sclFall & mackOk_q;
  wire readLoad = readFirst | readNext;
  wire [7:0] memData = mem[ptr_q];
  wire sendLast = (state_q == eea_pkg::ST_SEND) & sclFall & (bitCnt_q == 3'h0);
  wire sendShift = (state_q == eea_pkg::ST_SEND) & sclFall & (bitCnt_q != 3'h0);
  wire commitGo = stopSeen & gotData_q & ~wpLvl;
  // A poll during the write cycle must not drop the page being committed.
  wire dropBuf = ((startSeen | stopSeen) & ~busy_q) | (busy_q & (timer_q == 16'h0000));
  wire inCommit = busy_q & (timer_q[15:6] == 10'h000);
  wire [`EEA_PAGE_W-1:0] commitOfs = timer_q[5:0];
  wire commitWr = inCommit & valid_q[commitOfs];

  assign ptr_d = addrLoad ? {hi_q, shift_q} :
                 dataStore ? incAddr(ptr_q, 1'b1) :
                 readLoad ? incAddr(ptr_q, 1'b0) :
                 ptr_q;

  // ==========================================================================
  // Next protocol state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      eea_pkg::ST_IDLE: state_d = eea_pkg::ST_IDLE;
      eea_pkg::ST_RECV: if (byteDone) state_d = byteAck ? eea_pkg::ST_ACK : eea_pkg::ST_IGNORE;
      eea_pkg::ST_ACK: if (ackEnd) state_d = isRead_q ? eea_pkg::ST_SEND : eea_pkg::ST_RECV;
      eea_pkg::ST_SEND: if (sendLast) state_d = eea_pkg::ST_MACK;
      eea_pkg::ST_MACK: if (sclFall) state_d = mackOk_q ? eea_pkg::ST_SEND : eea_pkg::ST_IGNORE;
      eea_pkg::ST_IGNORE: state_d = eea_pkg::ST_IGNORE;
      default: state_d = eea_pkg::ST_IDLE;
    endcase
    if (startSeen)
      state_d = eea_pkg::ST_RECV;
    else if (stopSeen)
      state_d = eea_pkg::ST_IDLE;
  end

  // ==========================================================================
  // Bit and byte sequencing
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= eea_pkg::ST_IDLE;
      bitCnt_q <= 3'h0;
      full_q <= 1'b0;
      byteIdx_q <= `EEA_IDX_CTRL;
      isRead_q <= 1'b0;
      mackOk_q <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      if (startSeen)
      begin
        bitCnt_q <= 3'h0;
        full_q <= 1'b0;
        byteIdx_q <= `EEA_IDX_CTRL;
      end
      else if ((state_q == eea_pkg::ST_RECV) & sclRise & ~full_q)
      begin
        bitCnt_q <= bitCnt_q + 3'h1;
        full_q <= (bitCnt_q == 3'h7);
      end
      else if (byteDone)
      begin
        full_q <= 1'b0;
        if (byteIdx_q != `EEA_IDX_DATA)
          byteIdx_q <= byteIdx_q + 2'h1;
        if (idxCtrl)
          isRead_q <= shift_q[`EEA_CTRL_RW];
      end
      else if (readLoad)
        bitCnt_q <= 3'h7;
      else if (sendShift)
        bitCnt_q <= bitCnt_q - 3'h1;
      if ((state_q == eea_pkg::ST_MACK) & sclRise)
        mackOk_q <= ~sdaLvl;
    end
  end

  // ==========================================================================
  // Shift register and data line drive
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_q <= 8'h00;
      sdaOe_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end
    else if (clkEn)
    begin
      sdaOut_q <= 1'b0;
      if (startSeen | stopSeen)
        sdaOe_q <= 1'b0;
      else if ((state_q == eea_pkg::ST_RECV) & sclRise & ~full_q)
        shift_q <= {shift_q[6:0], sdaLvl};
      else if (byteDone)
        sdaOe_q <= byteAck;
      else if (readLoad)
      begin
        shift_q <= memData;
        sdaOe_q <= ~memData[7];
      end
      else if (sendShift)
      begin
        shift_q <= {shift_q[6:0], 1'b1};
        sdaOe_q <= ~shift_q[6];
      end
      else if (sclFall)
        sdaOe_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Address pointer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_q <= 15'h0000;
      hi_q <= 7'h00;
    end
    else if (clkEn)
    begin
      ptr_q <= ptr_d;
      if (hiLoad)
        hi_q <= shift_q[`EEA_HI_W-1:0];
    end
  end

  // ==========================================================================
  // Page buffer
  always_ff @(posedge ref_clk)
  begin
    if (clkEn & dataStore)
      pageBuf[ptr_q[5:0]] <= shift_q;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      valid_q <= 64'h0000000000000000;
      gotData_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (dataStore)
        valid_q[ptr_q[5:0]] <= 1'b1;
      else if (dropBuf & ~commitGo)
        valid_q <= 64'h0000000000000000;
      if (dataStore)
        gotData_q <= 1'b1;
      else if (startSeen | stopSeen)
        gotData_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Self-timed write cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
      timer_q <= 16'h0000;
      base_q <= 9'h000;
    end
    else if (clkEn)
    begin
      if (commitGo)
      begin
        busy_q <= 1'b1;
        timer_q <= WRITE_CYCLES - 16'h0001;
        base_q <= ptr_q[14:6];
      end
      else if (busy_q)
      begin
        if (timer_q == 16'h0000)
          busy_q <= 1'b0;
        else
          timer_q <= timer_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (clkEn & commitWr)
      mem[{base_q, commitOfs}] <= pageBuf[commitOfs];
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign writeBusy = busy_q;

endmodule

// File: verification/eea_bus_master.sv
`timescale 1ns/1ps
// ==========================================================================
// Two-wire bus master: clock low five cycles, high three.
module eea_bus_master (
  // Clock
  input wire logic ref_clk,
  // Bus
  input wire logic sdaIn,
  output logic scl,
  output logic sdaDrv,
  // Results: ack bits and read bytes
  output logic ev,
  output logic [7:0] evVal
);
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    ev = 1'b0;
    evVal = 8'h00;
  end
  task q(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task post(input logic [7:0] v);
    evVal <= v;
    ev <= 1'b1;
    q(1);
    ev <= 1'b0;
  endtask
  task xfer(input logic b, output logic r);
    sdaDrv <= b;
    q(2);
    scl <= 1'b1;
    q(2);
    r = sdaIn;
    q(1);
    scl <= 1'b0;
    q(3);
  endtask
  task start;
    sdaDrv <= 1'b1;
    q(2);
    scl <= 1'b1;
    q(2);
    sdaDrv <= 1'b0;
    q(2);
    scl <= 1'b0;
    q(3);
  endtask
  task stop;
    sdaDrv <= 1'b0;
    q(2);
    scl <= 1'b1;
    q(2);
    sdaDrv <= 1'b1;
    q(4);
  endtask
  task wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(b[i], r);
    xfer(1'b1, r);
    post({7'h00, ~r});
  endtask
  task rbyte(input logic mack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(~mack, r);
    post(d);
  endtask
endmodule

// File: verification/eea_serial_eeprom_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the serial EEPROM slave.
module eea_serial_eeprom_monitor #(
  parameter logic [15:0] WRITE_CYCLES = 16'h0064
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Two-wire bus
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Straps and status
  input wire logic writeProtect,
  input wire logic chipSelectBit0,
  input wire logic chipSelectBit1,
  input wire logic chipSelectBit2,
  input wire logic writeBusy
);
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;
  assign busyCnt_d = writeBusy ? busyCnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      busyCnt_q <= 16'h0000;
    else if (clkEn)
      busyCnt_q <= busyCnt_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_drive_low: assert property (sdaOut == 1'b0)
    else $error("data output not low");
  chk_busy_mute: assert property (writeBusy |-> !sdaOe)
    else $error("acknowledge during write cycle");
  chk_busy_len: assert property ($fell(writeBusy) |-> busyCnt_q == WRITE_CYCLES)
    else $error("write cycle length wrong");
  chk_busy_hold: assert property ($rose(writeBusy) |=> writeBusy [*8])
    else $error("write cycle cut short");
  chk_after_stop: assert property ($rose(writeBusy) |-> sclIn && sdaIn)
    else $error("write cycle began without stop");
  chk_wp_block: assert property ($rose(writeBusy) |-> !$past(writeProtect, 6))
    else $error("write cycle while protected");
  chk_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line moved while clock high");
  chk_reset_idle: assert property (disable iff (1'b0) !arst_n |-> !sdaOe && !writeBusy)
    else $error("outputs active in reset");
endmodule

bind eea_serial_eeprom eea_serial_eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .clkEn(clkEn),
  .sclIn(sclIn),
  .sdaIn(sdaIn),
  .sdaOut(sdaOut),
  .sdaOe(sdaOe),
  .writeProtect(writeProtect),
  .chipSelectBit0(chipSelectBit0),
  .chipSelectBit1(chipSelectBit1),
  .chipSelectBit2(chipSelectBit2),
  .writeBusy(writeBusy)
);

// File: verification/tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: the master model talks to the slave; a watcher scores results.
module tb;
  localparam logic [3:0] DT = 4'h5;
  logic ref_clk, arst_n, en, wp, scl, sdaDrv, sda, sdaOut, sdaOe, busy, ev;
  logic [2:0] cs;
  logic [7:0] evVal, b;
  logic [7:0] exq[$];
  logic [7:0] mem[int];
  logic [31:0] seed;
  int nFail, testsRun;
  assign sda = sdaDrv & ~sdaOe;
  eea_serial_eeprom #(.DEV_TYPE(DT), .WRITE_CYCLES(16'h0064)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .clkEn(en), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(wp),
    .chipSelectBit0(cs[0]), .chipSelectBit1(cs[1]), .chipSelectBit2(cs[2]), .writeBusy(busy));
  eea_bus_master bm (.ref_clk(ref_clk), .sdaIn(sda), .scl(scl), .sdaDrv(sdaDrv), .ev(ev), .evVal(evVal));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exv);
    testsRun++;
    if (seen !== exv)
    begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exv, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (ev === 1'b1)
    begin
      if (exq.size() == 0)
        chk("extra result", evVal, 8'hxx);
      else
        chk("bus result", evVal, exq.pop_front());
    end
  task wb(input logic [7:0] v, input logic a);
    exq.push_back({7'h00, a});
    bm.wbyte(v);
  endtask
  task ctl(input logic rw, input logic a);
    bm.start;
    wb({DT, cs, rw}, a);
  endtask
  task setp(input logic [15:0] ad);
    ctl(1'b0, 1'b1);
    wb(ad[15:8], 1'b1);
    wb(ad[7:0], 1'b1);
  endtask
  task wr(input logic [15:0] ad, input int n, input logic upd);
    setp(ad);
    for (int i = 0; i < n; i++)
    begin
      b = 8'(rnd());
      if (upd) mem[{ad[14:6], 6'(ad[5:0] + i)}] = b;
      wb(b, 1'b1);
    end
    bm.stop;
  endtask
  task rd(input logic [15:0] ad, input int n);
    for (int i = 0; i < n; i++)
    begin
      exq.push_back(mem[(ad + i) & 32'h7fff]);
      bm.rbyte(i != n - 1);
    end
    bm.stop;
  endtask
  task idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk);
    if (busy !== 1'b0)
    begin
      nFail++;
      finish_test;
    end
  endtask
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    nFail++;
    finish_test;
  end
  initial
  begin
    seed = 32'd87533;
    nFail = 0;
    testsRun = 0;
    arst_n = 1'b0;
    wp = 1'b0;
    en = 1'b1;
    cs = 3'(rnd());
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bm.start;
    wb({~DT, cs, 1'b0}, 1'b0);
    bm.start;
    wb({DT, cs ^ 3'h5, 1'b0}, 1'b0);
    wb(8'h00, 1'b0);
    bm.stop;
    wr(16'h803e, 66, 1'b1);
    ctl(1'b0, 1'b0);
    bm.stop;
    idle;
    ctl(1'b0, 1'b1);
    bm.stop;
    ctl(1'b1, 1'b1);
    rd(16'h0000, 64);
    wr(16'h7fff, 1, 1'b1);
    en <= 1'b0;
    repeat (200) @(posedge ref_clk);
    chk("frozen busy", {7'h00, busy}, 8'h01);
    en <= 1'b1;
    idle;
    setp(16'h7fff);
    ctl(1'b1, 1'b1);
    rd(16'h7fff, 2);
    wr(16'h0002, 1, 1'b1);
    repeat (8) @(posedge ref_clk);
    wp <= 1'b1;
    idle;
    wr(16'h0001, 1, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk("busy", {7'h00, busy}, 8'h00);
    ctl(1'b0, 1'b1);
    bm.stop;
    wp <= 1'b0;
    setp(16'h0001);
    ctl(1'b1, 1'b1);
    rd(16'h0001, 3);
    ctl(1'b1, 1'b1);
    rd(16'h0004, 1);
    repeat (20) @(posedge ref_clk);
    chk("pending", 8'(exq.size()), 8'h00);
    finish_test;
  end
endmodule
